// ===== msd_pkg.sv
`default_nettype none
package msd_pkg;
   // Byte offsets of the register map.
   localparam logic [7:0] MSD_CTRL_OFS = 8'h00;
   localparam logic [7:0] MSD_BOT_OFS = 8'h04;
   localparam logic [7:0] MSD_TOP_OFS = 8'h08;
   localparam logic [7:0] MSD_UNDER_OFS = 8'h0c;
   localparam logic [7:0] MSD_OVER_OFS = 8'h10;
   localparam logic [7:0] MSD_TOFS_OFS = 8'h14;
   localparam logic [7:0] MSD_TSPAN_OFS = 8'h18;
   localparam logic [7:0] MSD_TAREA_OFS = 8'h1c;
   localparam logic [7:0] MSD_PCNT_OFS = 8'h20;
   localparam logic [7:0] MSD_STAT_OFS = 8'h24;
   localparam logic [7:0] MSD_MASK_OFS = 8'h28;
   localparam logic [7:0] MSD_DISP_OFS = 8'h2c;
   localparam logic [7:0] MSD_NORM_OFS = 8'h30;
   localparam logic [7:0] MSD_KEY_OFS = 8'h34;
   localparam logic [7:0] MSD_TRIM_OFS = 8'h38;
   localparam logic [7:0] MSD_LEVEL_OFS = 8'h3c;
   localparam logic [7:0] MSD_TABLE_OFS = 8'h40;
   localparam int MSD_NPTS = 20;
   localparam logic [7:0] MSD_TABLE_END = 8'h90;
   // Control field positions and characteristic codes.
   localparam int MSD_CTRL_RANGE_BIT = 0;
   localparam int MSD_CTRL_CHAR_LSB = 1;
   localparam logic [2:0] MSD_CHAR_LINEAR = 3'h0;
   localparam logic [2:0] MSD_CHAR_SQUARE = 3'h1;
   localparam logic [2:0] MSD_CHAR_ROOT = 3'h2;
   localparam logic [2:0] MSD_CHAR_USER = 3'h3;
   localparam logic [2:0] MSD_CHAR_TANK = 3'h4;
   // Status bits.
   localparam int MSD_ST_DONE = 0;
   localparam int MSD_ST_FAULT = 1;
   // Nominal ranges in microamps; margins are in tenths of a percent.
   localparam logic signed [17:0] MSD_LO_4_20 = 18'sd4000;
   localparam logic signed [17:0] MSD_LO_0_20 = 18'sd0;
   localparam logic signed [17:0] MSD_HI_NOM = 18'sd20000;
   localparam logic signed [33:0] MSD_W_4_20 = 34'sd16000;
   localparam logic signed [33:0] MSD_W_0_20 = 34'sd20000;
   localparam logic signed [31:0] MSD_PERMILLE = 32'sd1000;
   localparam logic signed [11:0] MSD_X_FULL = 12'sd1000;
   localparam int MSD_FRAC = 16;
   localparam int MSD_AREA_SHIFT = 8;
   localparam int MSD_ROOT_BITS = 18;
   // Service password value is arbitrary.
   localparam logic [31:0] MSD_SERVICE_KEY = 32'h00005a3c;
   // Reset values.
   localparam logic [15:0] MSD_PCNT_RST = 16'h0002;
   localparam logic [15:0] MSD_TOP_RST = 16'h03e8;
   typedef struct packed {
      logic valid;
      logic [15:0] value;
   } msd_sample_t;
   typedef struct packed {
      logic valid;
      logic signed [31:0] display;
      logic signed [23:0] norm;
   } msd_result_t;
endpackage
`default_nettype wire

// ===== msd_top.sv
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`default_nettype none
// Contract
// RULE1: The normalised value starts by subtracting the low end of the range, 0 uA or 4000 uA.
// RULE2: The difference is divided by the range width, 20000 uA or 16000 uA, giving 0 to 1.
// RULE3: Samples outside the nominal range are normalised the same way with no clamping.
// RULE4: Linear output is norm times (top minus bottom) plus bottom.
// RULE5: A bottom value above the top value gives a falling characteristic.
// RULE6: Square output squares the norm and then scales as linear.
// RULE7: Root output takes the square root of the norm and then scales as linear.
// RULE8: Root output with a negative norm gives the bottom value.
// RULE9: The user table holds 2 to 20 X-Y points forming linear segments.
// RULE10: The user output is (norm minus low X) times segment slope times 100 plus low Y; the code scales the norm by 1000, X being in tenths of a percent.
// RULE11: Beyond the table ends the outermost segment is extrapolated.
// RULE12: Tank level is offset plus norm times span.
// RULE13: Tank volume is the integral of cross-section area over the level.
// RULE14: The fault lamp is lit while the sample is outside the permissible range.
// RULE15: Permissible limits are the low end less its under margin and the top end plus its over margin.
// RULE16: Maintenance settings open only after the correct service password is written.
// RULE17: Every new sample recomputes the norm, the display value and the fault lamp; the code drops samples that arrive while a conversion runs.
module msd_top
   import msd_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire msd_sample_t sample_in,
   output msd_result_t result_out,
   output logic fault_lamp,
   output logic irq
);
   typedef enum logic [1:0] {ST_IDLE, ST_NORM, ST_ROOT, ST_OUT} msd_state_t;

   msd_state_t state_r;
   // Settings written over the bus.
   logic [31:0] ctrl_r;
   logic signed [15:0] bot_r, top_r, tofs_r, tspan_r, trim_r;
   logic [15:0] under_r, over_r, tarea_r, pcnt_r;
   logic [1:0] stat_r, mask_r;
   logic unlock_r;
   logic [15:0] xpt_r [MSD_NPTS];
   logic signed [15:0] ypt_r [MSD_NPTS];
   // Conversion state and latched results.
   logic [15:0] samp_r;
   logic signed [23:0] norm_r;
   logic [MSD_ROOT_BITS-1:0] root_r;
   logic [4:0] bit_r;
   logic signed [31:0] level_r;

   // Bus decode: a write lands in the access cycle that the slave completes.
   wire acc = psel & penable & pready;
   wire wr_en = acc & pwrite;
   wire rd_set = psel & ~penable & ~pready;
   wire in_table = (paddr >= MSD_TABLE_OFS) && (paddr < MSD_TABLE_END) && (paddr[1:0] == 2'b00);
   wire [4:0] tidx = 5'((paddr - MSD_TABLE_OFS) >> 2);
   wire hit_reg = (paddr[1:0] == 2'b00) && (paddr < MSD_TABLE_OFS);
   // Only aligned offsets below the table, or inside it, answer without an error.
   wire mapped = in_table | hit_reg;
   // Control fields: range select and characteristic code.
   wire range_4_20 = ctrl_r[MSD_CTRL_RANGE_BIT];
   wire [2:0] char_mode = ctrl_r[MSD_CTRL_CHAR_LSB +: 3];
   wire [1:0] stat_w1c = (wr_en && paddr == MSD_STAT_OFS) ? pwdata[1:0] : 2'b00;
   // Write strobes for the registers whose writes have side effects.
   wire tbl_wr = wr_en & in_table;
   wire key_wr = wr_en && (paddr == MSD_KEY_OFS);
   wire key_ok = (pwdata == MSD_SERVICE_KEY);
   // A locked trim write is dropped without an error answer.
   wire trim_wr = wr_en && (paddr == MSD_TRIM_OFS) && unlock_r;

   // Sequencer decode; a sample that lands while busy is lost.
   wire busy = (state_r != ST_IDLE);
   wire take_sample = ~busy & sample_in.valid;
   wire conv_done = (state_r == ST_OUT);
   wire need_root = (char_mode == MSD_CHAR_ROOT);
   wire root_last = (bit_r == 5'd0);

   // Normalisation of the latched, trimmed sample.
   // The trim is added first, so the lamp sees it too.
   wire signed [17:0] samp_t = $signed({2'b00, samp_r}) + 18'(trim_r);
   wire signed [17:0] lo_nom = range_4_20 ? MSD_LO_4_20 : MSD_LO_0_20;
   wire signed [17:0] diff = samp_t - lo_nom; // see RULE1
   // The norm is Q16: 1.0 reads 65536, with room left for over-range samples.
   // Division truncates toward zero, so a negative norm rounds up by one step at most.
   wire signed [33:0] diff_q = {diff, 16'h0000};
   wire signed [33:0] width = range_4_20 ? MSD_W_4_20 : MSD_W_0_20;
   wire signed [33:0] norm_full = diff_q / width; // see RULE2 see RULE3

   // Permissible range limits; the lamp compares the raw trimmed sample.
   // Margins are in tenths of a percent, so 1000 equals the whole end value.
   // With the 0-20 range the low end is zero, so the under margin has no effect.
   // The limits follow the live settings; only the lamp decision is latched.
   wire signed [31:0] lo_cut = (32'(lo_nom) * $signed({16'h0000, under_r})) / MSD_PERMILLE;
   wire signed [31:0] hi_add = (32'(MSD_HI_NOM) * $signed({16'h0000, over_r})) / MSD_PERMILLE;
   wire signed [31:0] lo_lim = 32'(lo_nom) - lo_cut; // see RULE15
   wire signed [31:0] hi_lim = 32'(MSD_HI_NOM) + hi_add; // see RULE15
   wire out_of_range = (32'(samp_t) < lo_lim) || (32'(samp_t) > hi_lim); // see RULE14

   // Bit-serial square root of the norm held in fixed point.
   // One root bit is decided per cycle, highest first, so root mode is slower.
   // The radicand is the norm shifted up by 16 bits, so the root is Q16 as well.
   // A negative norm gives a meaningless root; the shaping below uses zero instead.
   wire signed [35:0] radicand = {norm_r, 12'h000} <<< 4;
   wire [MSD_ROOT_BITS-1:0] trial = root_r | (MSD_ROOT_BITS'(1) << bit_r);
   wire [35:0] trial_sq = 36'(trial) * 36'(trial);
   wire trial_ok = (trial_sq <= 36'(radicand));

   // Shaping term for the characteristics that share the linear scaling.
   // User and tank modes bypass this path and have their own arithmetic.
   wire signed [47:0] sq_full = norm_r * norm_r;
   logic signed [23:0] shaped;
   always_comb begin
      unique case (char_mode)
         MSD_CHAR_SQUARE: shaped = sq_full[39:16]; // see RULE6
         MSD_CHAR_ROOT: shaped = norm_r[23] ? 24'sd0 : $signed(24'(root_r)); // see RULE7 see RULE8
         default: shaped = norm_r; // see RULE4
      endcase
   end
   // An inverted scale is just a negative span, so no special case is needed.
   // The product keeps 16 fraction bits, dropped by an arithmetic shift that floors.
   wire signed [16:0] span = 17'(top_r) - 17'(bot_r); // see RULE5
   wire signed [40:0] lin_prod = shaped * span;
   wire signed [31:0] lin_out = 32'(lin_prod >>> MSD_FRAC) + 32'(bot_r); // see RULE4

   // Segment search: the first segment whose upper X lies above the norm, else the last one.
   // Points beyond the configured count are ignored and need not be written.
   // X is in tenths of a percent, so the norm is scaled by 1000 before the search.
   wire [4:0] npts = (pcnt_r < 16'd2) ? 5'd2 : (pcnt_r > 16'(MSD_NPTS)) ? 5'(MSD_NPTS) : pcnt_r[4:0]; // see RULE9
   wire signed [35:0] nx = norm_r * MSD_X_FULL;
   logic [4:0] seg;
   always_comb begin
      seg = npts - 5'd2; // see RULE11
      for (int i = MSD_NPTS - 2; i >= 0; i--) begin
         if ((5'(i) <= npts - 5'd2) && (nx < $signed({4'h0, xpt_r[i+1], 16'h0000}))) begin
            seg = 5'(i); // see RULE10
         end
      end
   end
   // A segment whose X ends coincide is treated as flat and returns its low Y.
   wire signed [16:0] xl = $signed({1'b0, xpt_r[seg]});
   wire signed [16:0] dx = $signed({1'b0, xpt_r[seg+5'd1]}) - xl;
   wire signed [16:0] dy = 17'(ypt_r[seg+5'd1]) - 17'(ypt_r[seg]);
   wire signed [35:0] nrel = nx - $signed({3'b000, xl, 16'h0000}); // see RULE11
   wire signed [52:0] seg_num = nrel * dy;
   wire signed [52:0] seg_q = (dx == 17'sd0) ? 53'sd0 : seg_num / 53'(dx);
   wire signed [31:0] user_out = 32'(seg_q >>> MSD_FRAC) + 32'(ypt_r[seg]); // see RULE10

   // Tank: level from the norm, then a vertical cylinder whose section is constant.
   // With a constant section the volume is simply level times area.
   // Both products keep their fraction bits and are floored by the shifts.
   wire signed [39:0] lvl_prod = norm_r * tspan_r;
   wire signed [31:0] level = 32'(lvl_prod >>> MSD_FRAC) + 32'(tofs_r); // see RULE12
   wire signed [48:0] vol_prod = level * $signed({1'b0, tarea_r});
   wire signed [31:0] volume = 32'(vol_prod >>> MSD_AREA_SHIFT); // see RULE13

   // Final selection of the displayed value.
   // Undefined codes fall through to the linear characteristic.
   logic signed [31:0] disp_sel;
   always_comb begin
      unique case (char_mode)
         MSD_CHAR_USER: disp_sel = user_out;
         MSD_CHAR_TANK: disp_sel = volume;
         default: disp_sel = lin_out;
      endcase
   end

   // Read mux.
   // Status reads show the busy flag and the lamp beside the sticky bits.
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (in_table) begin
         rd_mux = {ypt_r[tidx], xpt_r[tidx]};
      end else begin
         unique case (paddr)
            MSD_CTRL_OFS: rd_mux = {28'h0, ctrl_r[3:0]};
            MSD_BOT_OFS: rd_mux = 32'(bot_r);
            MSD_TOP_OFS: rd_mux = 32'(top_r);
            MSD_UNDER_OFS: rd_mux = {16'h0, under_r};
            MSD_OVER_OFS: rd_mux = {16'h0, over_r};
            MSD_TOFS_OFS: rd_mux = 32'(tofs_r);
            MSD_TSPAN_OFS: rd_mux = 32'(tspan_r);
            MSD_TAREA_OFS: rd_mux = {16'h0, tarea_r};
            MSD_PCNT_OFS: rd_mux = {16'h0, pcnt_r};
            MSD_STAT_OFS: rd_mux = {28'h0, fault_lamp, busy, stat_r};
            MSD_MASK_OFS: rd_mux = {30'h0, mask_r};
            MSD_DISP_OFS: rd_mux = result_out.display;
            MSD_NORM_OFS: rd_mux = 32'(result_out.norm);
            MSD_KEY_OFS: rd_mux = {31'h0, unlock_r};
            MSD_TRIM_OFS: rd_mux = 32'(trim_r);
            MSD_LEVEL_OFS: rd_mux = level_r;
            default: rd_mux = 32'h0000_0000;
         endcase
      end
   end

   // Bus answer: one cycle after setup the access phase completes.
   // Ready comes only from a setup cycle, so a held access cannot answer twice.
   // Read data is zero outside the access cycle so that stale words never show.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= rd_set;
         prdata <= (rd_set && !pwrite) ? rd_mux : 32'h0000_0000;
         pslverr <= rd_set & ~mapped;
      end
   end

   // Configuration registers written by software.
   // The point count is stored as written and clamped where it is used.
   // A setting changed during a conversion may mix old and new values.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_r <= 32'h0000_0000;
         bot_r <= 16'sh0000;
         top_r <= MSD_TOP_RST;
         under_r <= 16'h0000;
         over_r <= 16'h0000;
         tofs_r <= 16'sh0000;
         tspan_r <= 16'sh0000;
         tarea_r <= 16'h0000;
         pcnt_r <= MSD_PCNT_RST;
         mask_r <= 2'b00;
      end else if (wr_en) begin
         unique case (paddr)
            MSD_CTRL_OFS: ctrl_r <= {28'h0, pwdata[3:0]};
            MSD_BOT_OFS: bot_r <= pwdata[15:0];
            MSD_TOP_OFS: top_r <= pwdata[15:0];
            MSD_UNDER_OFS: under_r <= pwdata[15:0];
            MSD_OVER_OFS: over_r <= pwdata[15:0];
            MSD_TOFS_OFS: tofs_r <= pwdata[15:0];
            MSD_TSPAN_OFS: tspan_r <= pwdata[15:0];
            MSD_TAREA_OFS: tarea_r <= pwdata[15:0];
            MSD_PCNT_OFS: pcnt_r <= pwdata[15:0];
            MSD_MASK_OFS: mask_r <= pwdata[1:0];
            default: mask_r <= mask_r;
         endcase
      end
   end

   // Point table; points are kept in X order by software.
   // The table has no reset, so software writes every point that it enables.
   always_ff @(posedge clk) begin
      if (tbl_wr) begin
         xpt_r[tidx] <= pwdata[15:0]; // see RULE9
         ypt_r[tidx] <= pwdata[31:16];
      end
   end

   // Service lock: only the exact password opens the maintenance trim.
   // Any other key value locks the trim again.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         unlock_r <= 1'b0;
         trim_r <= 16'sh0000;
      end else if (key_wr) begin
         unlock_r <= key_ok; // see RULE16
      end else if (trim_wr) begin
         trim_r <= pwdata[15:0]; // see RULE16
      end
   end

   // Conversion sequencer; samples arriving while busy are dropped.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= ST_IDLE;
         samp_r <= 16'h0000;
         norm_r <= 24'sd0;
         root_r <= '0;
         bit_r <= 5'd0;
      end else begin
         unique case (state_r)
            // Idle: wait for a fresh sample.
            ST_IDLE: begin
               if (take_sample) begin
                  samp_r <= sample_in.value; // see RULE17
                  state_r <= ST_NORM;
               end
            end
            // Normalise, then pick the root pass or go straight to the output.
            ST_NORM: begin
               norm_r <= norm_full[23:0];
               root_r <= '0;
               bit_r <= 5'(MSD_ROOT_BITS - 1);
               state_r <= need_root ? ST_ROOT : ST_OUT;
            end
            // Root: one bit per cycle down to bit zero.
            ST_ROOT: begin
               if (trial_ok) begin
                  root_r <= trial; // see RULE7
               end
               bit_r <= bit_r - 5'd1;
               if (root_last) begin
                  state_r <= ST_OUT;
               end
            end
            // Output: the result registers load here.
            ST_OUT: state_r <= ST_IDLE;
         endcase
      end
   end

   // Result registers and the lamp, refreshed once per conversion.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         result_out <= '0;
         fault_lamp <= 1'b0;
         level_r <= 32'sd0;
      end else begin
         // Display and norm hold between conversions; only valid pulses.
         result_out.valid <= conv_done;
         if (conv_done) begin
            result_out.display <= disp_sel; // see RULE17
            result_out.norm <= norm_r;
            fault_lamp <= out_of_range; // see RULE14
            level_r <= level;
         end
      end
   end

   // Sticky events, write one to clear; a new event wins over the clear.
   wire [1:0] ev = {conv_done & out_of_range, conv_done};
   // The interrupt is formed from the next status, so it rises with the status bit.
   wire [1:0] stat_nxt = (stat_r & ~stat_w1c) | ev;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stat_r <= 2'b00;
         irq <= 1'b0;
      end else begin
         stat_r <= stat_nxt;
         irq <= |(stat_nxt & mask_r);
      end
   end
endmodule
`default_nettype wire

// ===== msd_front_end.sv
`default_nettype none
module msd_front_end
   import msd_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic go,
   input wire logic [15:0] amps,
   output msd_sample_t sample
);
   timeunit 1ns;
   timeprecision 1ns;
   // Flags one fresh sample per request cycle; between samples the value lines toggle so a stale value never reads as new.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sample <= '0;
      end else begin
         sample.valid <= go;
         sample.value <= go ? amps : ~sample.value;
      end
   end
endmodule
`default_nettype wire

// ===== msd_top_asserts.sv
`default_nettype none
module msd_top_asserts
   import msd_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire msd_sample_t sample_in,
   input wire msd_result_t result_out,
   input wire logic fault_lamp,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking dcb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Bus answers take exactly one access cycle, and data or error only show with it.
   ready_after_setup_a: assert property (psel && !penable |=> pready) else $error("no pready after setup");
   ready_single_a: assert property (pready |=> !pready) else $error("pready held too long");
   err_with_ready_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
   idle_data_zero_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero when idle");
   // Each result follows a taken sample by 3 or 21 cycles, pulses once and holds its values.
   result_delay_a: assert property (
      result_out.valid |-> $past(sample_in.valid, 3) || $past(sample_in.valid, 21))
      else $error("result without sample");
   result_pulse_a: assert property (result_out.valid |=> !result_out.valid) else $error("result too long");
   value_hold_a: assert property (
      !result_out.valid |-> $stable(result_out.display) && $stable(result_out.norm))
      else $error("result changed between conversions");
   lamp_update_a: assert property ($changed(fault_lamp) |-> result_out.valid) else $error("lamp moved alone");
   irq_cause_a: assert property ($rose(irq) |-> result_out.valid || $past(pready && pwrite)
      || $past(pready && pwrite, 2)) else $error("irq rose without cause");
   // Main scenarios reached.
   root_seen_c: cover property (result_out.valid && $past(sample_in.valid, 21));
   err_seen_c: cover property (pslverr);
   irq_seen_c: cover property ($rose(irq));
   lamp_seen_c: cover property ($rose(fault_lamp));
endmodule
bind msd_top msd_top_asserts chk (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_in(sample_in),
   .result_out(result_out), .fault_lamp(fault_lamp), .irq(irq));
`default_nettype wire

// ===== msd_top_bench.sv
`default_nettype none
module msd_top_bench import msd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic signed [31:0] d; logic signed [23:0] n; logic l;} msd_exp_t;
   logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, fault_lamp, irq, go;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] amps;
   msd_sample_t sample_in;
   msd_result_t result_out;
   msd_exp_t expq[$];
   msd_exp_t me;
   int n_mismatch = 0;
   int total_checks = 0;
   longint cfg[64];
   longint px[3], py[3];
   msd_top dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_in(sample_in),
      .result_out(result_out), .fault_lamp(fault_lamp), .irq(irq));
   msd_front_end fe (.clk(clk), .sys_rst(sys_rst), .go(go), .amps(amps), .sample(sample_in));
   // Clock and watchdog.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #(40 * 6000);
      n_mismatch++;
      report_and_stop();
   end
   function automatic longint isqrt(input longint v);
      longint r;
      r = 0;
      for (int b = 18; b >= 0; b--) if ((r | (64'sd1 << b)) ** 2 <= v) r = r | (64'sd1 << b);
      return r;
   endfunction
   // Expected display, norm and lamp from the mirrored settings.
   function automatic msd_exp_t ex(input longint s);
      msd_exp_t e;
      longint t, lo, n, f, i, nx, ch;
      t = s + cfg[14];
      lo = cfg[0][0] ? 4000 : 0;
      ch = (cfg[0] >> 1) & 7;
      n = ((t - lo) * 65536) / (cfg[0][0] ? 16000 : 20000);
      f = (ch == 1) ? (n * n) >>> 16 : (ch == 2) ? (n < 0 ? 0 : isqrt(n * 65536)) : n;
      e.d = ((f * (cfg[2] - cfg[1])) >>> 16) + cfg[1];
      nx = n * 1000;
      i = (nx < (px[1] <<< 16)) ? 0 : 1;
      if (ch == 3) e.d = ((((nx - (px[i] <<< 16)) * (py[i + 1] - py[i])) / (px[i + 1] - px[i])) >>> 16) + py[i];
      if (ch == 4) e.d = ((((n * cfg[6]) >>> 16) + cfg[5]) * cfg[7]) >>> 8;
      e.n = n;
      e.l = (t < lo - lo * cfg[3] / 1000) || (t > 20000 + 20000 * cfg[4] / 1000);
      return e;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One APB transfer, then one idle cycle.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = pslverr ? 32'hdead : prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input longint d);
      cfg[a >> 2] = d;
      apb(1'b1, a, d[31:0]);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("read data", e, rd);
   endtask
   task automatic pt(input int i, input longint x, input longint y);
      px[i] = x;
      py[i] = y;
      wr(MSD_TABLE_OFS + 8'(4 * i), {y[15:0], x[15:0]});
   endtask
   // Notes the expectation, requests a sample (twice in a row if asked) and waits for the result.
   task automatic conv(input longint s, input int twice = 0);
      int k;
      k = 0;
      expq.push_back(ex(s));
      go <= 1'b1;
      amps <= s[15:0];
      if (twice != 0) @(posedge clk);
      @(posedge clk);
      go <= 1'b0;
      do begin
         @(posedge clk);
         k++;
      end while (result_out.valid !== 1'b1 && k < 40);
      chk("result timeout", 32'h1, 32'(k < 40));
      @(posedge clk);
   endtask
   // Compares every result with the oldest expectation.
   always @(posedge clk) begin
      if (result_out.valid === 1'b1) begin
         if (expq.size() == 0) begin
            chk("spare result", 32'h0, 32'h1);
         end else begin
            me = expq.pop_front();
            chk("display", me.d, result_out.display);
            chk("norm", me.n, result_out.norm);
            chk("fault lamp", 32'(me.l), 32'(fault_lamp));
         end
      end
   end
   task automatic report_and_stop();
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata, go, amps} = '0;
      sys_rst = 1'b1;
      cfg = '{default: 0};
      cfg[2] = 1000;
      void'($urandom(32'h8a27));
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rdchk(MSD_TOP_OFS, 32'h3e8);
      rdchk(MSD_PCNT_OFS, 32'h2);
      rdchk(MSD_CTRL_OFS, 32'h0);
      rdchk(8'h9c, 32'hdead);
      rdchk(8'h05, 32'hdead);
      wr(MSD_CTRL_OFS, 1);
      wr(MSD_BOT_OFS, -300);
      wr(MSD_TOP_OFS, 1200);
      conv(10000);
      conv(2500);
      conv(20500);
      chk("irq masked", 32'h0, 32'(irq));
      wr(MSD_BOT_OFS, 1200);
      wr(MSD_TOP_OFS, -300);
      conv(3000);
      conv(19000);
      wr(MSD_BOT_OFS, -300);
      wr(MSD_TOP_OFS, 1200);
      wr(MSD_CTRL_OFS, 3);
      conv(10000);
      conv(2500);
      wr(MSD_CTRL_OFS, 5);
      conv(10000);
      conv(2500);
      wr(MSD_CTRL_OFS, 6);
      pt(0, 0, -50);
      pt(1, 500, 100);
      pt(2, 1000, 0);
      wr(MSD_PCNT_OFS, 3);
      conv(5000);
      conv(15000);
      conv(22000);
      wr(MSD_CTRL_OFS, 8);
      wr(MSD_TOFS_OFS, 100);
      wr(MSD_TSPAN_OFS, 1000);
      wr(MSD_TAREA_OFS, 256);
      conv(10000);
      rdchk(MSD_LEVEL_OFS, 32'd600);
      wr(MSD_CTRL_OFS, 1);
      wr(MSD_UNDER_OFS, 200);
      wr(MSD_OVER_OFS, 100);
      conv(3199);
      conv(3200);
      conv(22000);
      conv(22001);
      wr(MSD_CTRL_OFS, 0);
      wr(MSD_OVER_OFS, 0);
      repeat (8) conv($urandom_range(0, 25000));
      conv(10000, 1);
      apb(1'b1, MSD_TRIM_OFS, 32'd500);
      conv(10000);
      wr(MSD_KEY_OFS, MSD_SERVICE_KEY);
      rdchk(MSD_KEY_OFS, 32'h1);
      wr(MSD_TRIM_OFS, 500);
      conv(10000);
      wr(MSD_TRIM_OFS, 0);
      wr(MSD_KEY_OFS, 0);
      rdchk(MSD_KEY_OFS, 32'h0);
      wr(MSD_MASK_OFS, 1);
      @(posedge clk);
      chk("irq raised", 32'h1, 32'(irq));
      wr(MSD_STAT_OFS, 3);
      @(posedge clk);
      chk("irq cleared", 32'h0, 32'(irq));
      rdchk(MSD_STAT_OFS, 32'h0);
      conv(9000);
      @(posedge clk);
      chk("irq event", 32'h1, 32'(irq));
      report_and_stop();
   end
endmodule
`default_nettype wire
